// file: hw/dog_pkg.sv
// Shared constants for the watchdog and reset-cause block
package dog_pkg;

	// Clock and watchdog oscillator periods, in picoseconds
	localparam int SYS_CLK_PERIOD_PS = 4000;
	localparam int DOG_OSC_PERIOD_PS = 1000000;
	localparam int DOG_TICK_DIV      = DOG_OSC_PERIOD_PS / SYS_CLK_PERIOD_PS;

	// Unlock window length in core clock cycles
	localparam int UNLOCK_CYCLES = 4;

	// Shortest timeout in watchdog oscillator cycles (16K)
	localparam int DOG_BASE_CYCLES = 16 * 1024;
	localparam int DOG_CNT_W       = 22;

	// Register bus geometry and offsets
	localparam int              ADDR_W      = 4;
	localparam logic [3:0]      STATUS_OFS  = 4'h0;
	localparam logic [3:0]      CONTROL_OFS = 4'h4;
	localparam logic [1:0]      RESP_OKAY   = 2'h0;
	localparam logic [1:0]      RESP_SLVERR = 2'h2;

	// Reset-cause status fields
	localparam int CAUSE_W   = 5;
	localparam int SCAN_BIT  = 4;
	localparam int DOG_BIT   = 3;
	localparam int BROWN_BIT = 2;
	localparam int PIN_BIT   = 1;
	localparam int PWRUP_BIT = 0;

	// Watchdog control fields
	localparam int CTRL_W     = 5;
	localparam int UNLOCK_BIT = 4;
	localparam int ENABLE_BIT = 3;
	localparam int PERIOD_MSB = 2;
	localparam int PERIOD_W   = 3;

	// Order of the synchronised pin inputs
	localparam int SYNC_W     = 5;
	localparam int SY_PWRUP   = 0;
	localparam int SY_PIN     = 1;
	localparam int SY_BROWN   = 2;
	localparam int SY_SCAN    = 3;
	localparam int SY_FUSE    = 4;

endpackage

// file: hw/pin_sync.sv
// Two-flop synchronisers for a group of asynchronous levels
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// One pair of flops per bit; the first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic meta_reg;
			always_ff @(posedge sys_clk)
			begin
				if (rst)
				begin
					meta_reg    <= 1'h0;
					sync_out[i] <= 1'h0;
				end
				else
				begin
					meta_reg    <= async_in[i];
					sync_out[i] <= meta_reg;
				end
			end
		end
	endgenerate

endmodule

// file: hw/dog_tick_div.sv
// Divider that stands in for the watchdog oscillator as a tick enable
`timescale 1ns/1ps
module dog_tick_div #(
	parameter int DIV = 250
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// One-cycle tick per oscillator period
	output logic      tick
);

	localparam int CW = $clog2(DIV + 1);
	logic [CW-1:0] div_reg;

	// Free-running count, tick on wrap
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			div_reg <= '0;
			tick    <= 1'h0;
		end
		else if (div_reg == CW'(DIV - 1))
		begin
			div_reg <= '0;
			tick    <= 1'h1;
		end
		else
		begin
			div_reg <= div_reg + CW'(1);
			tick    <= 1'h0;
		end
	end

endmodule

// file: hw/dog_reset_cause.sv
// Watchdog timer control and reset-cause flags behind an AXI4-Lite slave
//
// How it works
// - Scan core-reset level sets the scan reset flag.
// - Each watchdog reset pulse sets the watchdog reset flag.
// - Brown-out reset sets the brownout reset flag.
// - External pin reset sets the pin reset flag.
// - Power-on reset sets the power-up reset flag.
// - Four non-power flags clear on power-on reset or written zero.
// - Power-up flag clears only by a written zero, never by reset.
// - Control bits seven to five always read zero.
// - Unlock bit clears itself four clock cycles after being set.
// - Enable clears only while the unlock bit is one.
// - Period bits change only while the unlock bit is set.
// - Writing enable one always enables; zero disables when permitted.
// - Always-on level refuses every disable.
// - Period code selects 16K doubling to 2048K oscillator cycles.
// - Counter runs on its own 1 MHz oscillator tick.
// - Counter restarts on kick, when disabled and on chip reset.
// - Expiry without kick gives a one-cycle reset pulse.
// - Fuse starts enabled, enable reads one, period still locked.
`timescale 1ns/1ps
module dog_reset_cause
	import dog_pkg::*;
#(
	parameter int BASE_CYCLES = DOG_BASE_CYCLES,
	parameter int TICK_DIV    = DOG_TICK_DIV
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst,
	// AXI4-Lite write address and data
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Reset sources and fuse, asynchronous levels
	input  wire logic              powerup_level,
	input  wire logic              pin_reset_level,
	input  wire logic              brownout_level,
	input  wire logic              scan_core_reset_level,
	input  wire logic              dog_always_on_fuse,
	// Core side
	input  wire logic              dog_kick,
	output logic                   dog_reset_pulse
);

	logic [ADDR_W-1:0]     awaddr_reg;
	logic [7:0]            wdata_reg;
	logic                  wstrb0_reg;
	logic [SYNC_W-1:0]     sync_lvl;
	logic                  tick;
	logic                  wr_do;
	logic                  wr_hit_st;
	logic                  wr_hit_ctrl;
	logic                  st_wr;
	logic                  ctrl_wr;
	logic                  open_req;
	logic                  unlock_reg;
	logic [2:0]            unlock_cnt_reg;
	logic                  enable_reg;
	logic [PERIOD_W-1:0]   period_reg;
	logic                  dog_on;
	logic [DOG_CNT_W-1:0]  dog_cnt_reg;
	logic [DOG_CNT_W-1:0]  dog_limit;
	logic                  dog_fire;
	logic [CAUSE_W-1:0]    cause_reg = '0;
	logic [CAUSE_W-1:0]    cause_set;
	logic [CAUSE_W-1:0]    cause_keep;
	logic [CAUSE_W-1:0]    cause_next;
	logic [31:0]           rd_word;
	logic                  rd_hit;

	// Reset sources and fuse cross into the core clock
	pin_sync #(
		.WIDTH (SYNC_W)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({dog_always_on_fuse, scan_core_reset_level, brownout_level,
		            pin_reset_level, powerup_level}),
		.sync_out (sync_lvl)
	);

	// Oscillator tick for the watchdog counter
	dog_tick_div #(
		.DIV (TICK_DIV)
	) u_tick (
		.sys_clk (sys_clk),
		.rst     (rst),
		.tick    (tick)
	);

	// Write address capture; ready drops while an address is held
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'h1;
			awaddr_reg    <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			s_axi_awready <= 1'h0;
			awaddr_reg    <= s_axi_awaddr;
		end
		else if (wr_do)
			s_axi_awready <= 1'h1;
	end

	// Write data capture, only byte lane 0 carries register bits
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_axi_wready <= 1'h1;
			wdata_reg    <= '0;
			wstrb0_reg   <= 1'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			s_axi_wready <= 1'h0;
			wdata_reg    <= s_axi_wdata[7:0];
			wstrb0_reg   <= s_axi_wstrb[0];
		end
		else if (wr_do)
			s_axi_wready <= 1'h1;
	end

	// Write executes once address and data are both held
	assign wr_do       = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_hit_st   = awaddr_reg[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2];
	assign wr_hit_ctrl = awaddr_reg[ADDR_W-1:2] == CONTROL_OFS[ADDR_W-1:2];
	assign st_wr       = wr_do && wr_hit_st && wstrb0_reg;
	assign ctrl_wr     = wr_do && wr_hit_ctrl && wstrb0_reg;

	// Write response, error for unmapped addresses
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_axi_bvalid <= 1'h0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (wr_do)
		begin
			s_axi_bvalid <= 1'h1;
			s_axi_bresp  <= (wr_hit_st || wr_hit_ctrl) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'h0;
	end

	// Read mux; reserved control bits stay zero
	always_comb
	begin
		rd_hit  = 1'h1;
		rd_word = '0;
		if (s_axi_araddr[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2])
			rd_word = 32'(cause_reg);
		else if (s_axi_araddr[ADDR_W-1:2] == CONTROL_OFS[ADDR_W-1:2])
			rd_word = 32'({unlock_reg, dog_on, period_reg});
		else
			rd_hit = 1'h0;
	end

	// Read channel, one read in flight
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid  <= 1'h0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'h0;
			s_axi_rvalid  <= 1'h1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid  <= 1'h0;
		end
	end

	// Unlock window opens on a write of unlock and enable together
	assign open_req = ctrl_wr && wdata_reg[UNLOCK_BIT] && wdata_reg[ENABLE_BIT];

	// Unlock bit self-clears after the window, or on the completing write
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			unlock_reg     <= 1'h0;
			unlock_cnt_reg <= '0;
		end
		else if (open_req)
		begin
			unlock_reg     <= 1'h1;
			unlock_cnt_reg <= 3'(UNLOCK_CYCLES - 1);
		end
		else if (ctrl_wr && unlock_reg)
			unlock_reg <= 1'h0;
		else if (unlock_reg && unlock_cnt_reg == '0)
			unlock_reg <= 1'h0;
		else if (unlock_reg)
			unlock_cnt_reg <= unlock_cnt_reg - 3'(1);
	end

	// Enable sets freely but clears only inside the window
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			enable_reg <= 1'h0;
		else if (ctrl_wr && wdata_reg[ENABLE_BIT])
			enable_reg <= 1'h1;
		else if (ctrl_wr && unlock_reg)
			enable_reg <= 1'h0;
	end

	// Period changes only by the completing write inside the window
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			period_reg <= '0;
		else if (ctrl_wr && unlock_reg && !wdata_reg[UNLOCK_BIT])
			period_reg <= wdata_reg[PERIOD_MSB:0];
	end

	// The fuse forces the timer on whatever the enable bit holds
	assign dog_on = enable_reg || sync_lvl[SY_FUSE];

	// Timeout is the base count doubled per period code step
	assign dog_limit = DOG_CNT_W'(BASE_CYCLES) << period_reg;
	assign dog_fire  = tick && dog_on && !dog_kick && (dog_cnt_reg >= dog_limit - DOG_CNT_W'(1));

	// Watchdog counter advances once per oscillator tick
	always_ff @(posedge sys_clk)
	begin
		if (rst || !dog_on || dog_kick || dog_fire)
			dog_cnt_reg <= '0;
		else if (tick)
			dog_cnt_reg <= dog_cnt_reg + DOG_CNT_W'(1);
	end

	// Reset pulse lasts one core cycle
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			dog_reset_pulse <= 1'h0;
		else
			dog_reset_pulse <= dog_fire;
	end

	// Hardware set terms for each flag
	assign cause_set[SCAN_BIT]  = sync_lvl[SY_SCAN];
	assign cause_set[DOG_BIT]   = dog_reset_pulse;
	assign cause_set[BROWN_BIT] = sync_lvl[SY_BROWN];
	assign cause_set[PIN_BIT]   = sync_lvl[SY_PIN];
	assign cause_set[PWRUP_BIT] = sync_lvl[SY_PWRUP];

	// Written zeros and power-on clear; sets win over clears
	always_comb
	begin
		cause_keep = st_wr ? wdata_reg[CAUSE_W-1:0] : '1;
		if (sync_lvl[SY_PWRUP])
			cause_keep = cause_keep & CAUSE_W'(1 << PWRUP_BIT);
		cause_next = (cause_reg & cause_keep) | cause_set;
	end

	// Status flags survive the block reset; power-on clears all but the power-up flag
	always_ff @(posedge sys_clk)
	begin
		cause_reg <= cause_next;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Window stays open four cycles when left alone, then closes
	sequence s_window_opened;
		$rose(unlock_reg) ##0 (!ctrl_wr)[*3];
	endsequence
	sequence s_window_expires;
		##1 unlock_reg ##1 !unlock_reg;
	endsequence
	a_unlock_self_clear: assert property (s_window_opened |-> s_window_expires)
		else $error("unlock bit did not clear after four cycles");

	a_disable_locked: assert property (ctrl_wr && !unlock_reg && dog_on |=> dog_on)
		else $error("watchdog disabled outside the unlock window");

	a_period_locked: assert property (ctrl_wr && !unlock_reg |=> $stable(period_reg))
		else $error("period changed outside the unlock window");

	a_enable_accepted: assert property (ctrl_wr && wdata_reg[ENABLE_BIT] |=> dog_on && enable_reg)
		else $error("enable write was not accepted");

	a_fuse_no_disable: assert property (sync_lvl[SY_FUSE] ##1 sync_lvl[SY_FUSE] |-> dog_on)
		else $error("watchdog off while always-on fuse is set");

	a_pulse_one_cycle: assert property (dog_reset_pulse |=> !dog_reset_pulse ##1 cause_reg[DOG_BIT])
		else $error("reset pulse too long or flag not set");

	a_kick_restart: assert property (dog_kick |=> dog_cnt_reg == '0 ##1 dog_cnt_reg <= DOG_CNT_W'(1))
		else $error("counter not restarted by kick");

	a_set_beats_clear: assert property (st_wr && !wdata_reg[PIN_BIT] && sync_lvl[SY_PIN] |=> cause_reg[PIN_BIT])
		else $error("pin flag lost to a simultaneous clear");

	a_scan_flag_set: assert property (sync_lvl[SY_SCAN] |=> cause_reg[SCAN_BIT])
		else $error("scan reset flag not set");

	a_powerup_clears: assert property (sync_lvl[SY_PWRUP] && !cause_set[BROWN_BIT] |=>
		cause_reg[PWRUP_BIT] && !cause_reg[BROWN_BIT])
		else $error("power-on did not set power-up and clear brownout");

	a_powerup_sticky: assert property (@(posedge sys_clk) disable iff (1'b0)
		!st_wr |=> !$fell(cause_reg[PWRUP_BIT]))
		else $error("power-up flag cleared without a write");

	a_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:CTRL_W] == '0)
		else $error("reserved bits read non-zero");

endmodule

// file: bench/dog_reset_cause_tb.sv
// Self-checking bench for the watchdog and reset-cause block
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module dog_reset_cause_tb
	import dog_pkg::*;
;
	// Bus, source and core signals
	logic              sys_clk;
	logic              rst;
	logic [ADDR_W-1:0] s_axi_awaddr;
	logic              s_axi_awvalid;
	logic              s_axi_awready;
	logic [31:0]       s_axi_wdata;
	logic [3:0]        s_axi_wstrb;
	logic              s_axi_wvalid;
	logic              s_axi_wready;
	logic [1:0]        s_axi_bresp;
	logic              s_axi_bvalid;
	logic              s_axi_bready;
	logic [ADDR_W-1:0] s_axi_araddr;
	logic              s_axi_arvalid;
	logic              s_axi_arready;
	logic [31:0]       s_axi_rdata;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_rvalid;
	logic              s_axi_rready;
	logic [3:0]        src;
	logic              fuse;
	logic              dog_kick;
	logic              dog_reset_pulse;
	// Scoreboard state
	int                n_errors;
	int                cmp_count;
	int                n_pulse;
	int                n0;
	int                p;
	logic [33:0]       rq[$];
	logic [1:0]        bq[$];
	logic [33:0]       exp_r;
	logic [1:0]        exp_b;

	// Short counts so a timeout is 32 cycles at period code 0, doubling per code step
	dog_reset_cause #(.BASE_CYCLES(16), .TICK_DIV(2)) i_dut (
		.sys_clk(sys_clk), .rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.powerup_level(src[0]), .pin_reset_level(src[1]), .brownout_level(src[2]),
		.scan_core_reset_level(src[3]), .dog_always_on_fuse(fuse),
		.dog_kick(dog_kick), .dog_reset_pulse(dog_reset_pulse)
	);

	// Core clock, 4 ns period
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// Verdict and end of run
	task test_done();
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// A wait that ran out of cycles
	task hang();
		n_errors++;
		test_done();
	endtask

	// Bus write; address and data offered together
	task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
		bit done;
		done = 1'b0;
		bq.push_back(r);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 100 && !done; i++)
		begin
			@(posedge sys_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			done = s_axi_bvalid;
		end
		s_axi_bready <= 1'b0;
		if (!done)
			hang();
	endtask

	// Bus read; expected response and byte noted first
	task rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
		bit done;
		done = 1'b0;
		rq.push_back({r, 24'h0, d});
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 100 && !done; i++)
		begin
			@(posedge sys_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			done = s_axi_rvalid;
		end
		s_axi_rready <= 1'b0;
		if (!done)
			hang();
	endtask

	// One reset source held high for a while
	task lvl(input int k);
		@(posedge sys_clk);
		src[k] <= 1'b1;
		repeat (6) @(posedge sys_clk);
		src[k] <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	// Block reset pulse
	task rs();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
	endtask

	// One-cycle kick
	task kick();
		@(posedge sys_clk);
		dog_kick <= 1'b1;
		@(posedge sys_clk);
		dog_kick <= 1'b0;
	endtask

	// Waits for a timeout pulse near ex cycles, then checks it lasted one cycle;
	// the first edge lets a pulse from just before the kick go by
	task wp(input int ex);
		int c;
		@(posedge sys_clk);
		for (c = 0; c < ex + 10 && !dog_reset_pulse; c++)
			@(posedge sys_clk);
		`CHK(c >= ex - 8, 1'b1)
		if (!dog_reset_pulse)
			hang();
		@(posedge sys_clk);
		`CHK(dog_reset_pulse, 1'b0)
	endtask

	// Takes the oldest note whenever a response appears
	always @(posedge sys_clk)
	begin
		if (s_axi_bvalid && s_axi_bready)
		begin
			exp_b = bq.pop_front();
			`CHK(s_axi_bresp, exp_b)
		end
		if (s_axi_rvalid && s_axi_rready)
		begin
			exp_r = rq.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, exp_r)
		end
		if (dog_reset_pulse)
			n_pulse++;
	end

	// Main sequence
	initial
	begin
		{n_errors, cmp_count, n_pulse} = '0;
		{rst, src, fuse, dog_kick} = 7'h40;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h00, 32'h0, 4'h1};
		void'($urandom(32'h643ab92d));
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		lvl(0);
		rd(STATUS_OFS, 8'h01, RESP_OKAY);
		lvl(1);
		rd(STATUS_OFS, 8'h03, RESP_OKAY);
		lvl(2);
		rd(STATUS_OFS, 8'h07, RESP_OKAY);
		lvl(3);
		rd(STATUS_OFS, 8'h17, RESP_OKAY);
		rd(CONTROL_OFS, 8'h00, RESP_OKAY);
		rd(4'h8, 8'h00, RESP_SLVERR);
		wr(4'hc, 8'h00, RESP_SLVERR);
		wr(STATUS_OFS, 8'h1e, RESP_OKAY);
		rs();
		rd(STATUS_OFS, 8'h16, RESP_OKAY);
		lvl(0);
		rd(STATUS_OFS, 8'h01, RESP_OKAY);
		rs();
		rd(STATUS_OFS, 8'h01, RESP_OKAY);
		// A write with lane 0 off leaves the flags alone
		s_axi_wstrb <= 4'h0;
		wr(STATUS_OFS, 8'h00, RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(STATUS_OFS, 8'h01, RESP_OKAY);
		wr(STATUS_OFS, 8'h00, RESP_OKAY);
		rd(STATUS_OFS, 8'h00, RESP_OKAY);
		// Pin level held through a written zero keeps its flag
		src[1] <= 1'b1;
		wr(STATUS_OFS, 8'h00, RESP_OKAY);
		rd(STATUS_OFS, 8'h02, RESP_OKAY);
		src[1] <= 1'b0;
		repeat (4) @(posedge sys_clk);
		wr(STATUS_OFS, 8'h00, RESP_OKAY);
		rd(STATUS_OFS, 8'h00, RESP_OKAY);
		// Protected fields outside the unlock window
		wr(CONTROL_OFS, 8'h08, RESP_OKAY);
		rd(CONTROL_OFS, 8'h08, RESP_OKAY);
		wr(CONTROL_OFS, 8'h07, RESP_OKAY);
		rd(CONTROL_OFS, 8'h08, RESP_OKAY);
		wr(CONTROL_OFS, 8'h18, RESP_OKAY);
		repeat (10) @(posedge sys_clk);
		wr(CONTROL_OFS, 8'h00, RESP_OKAY);
		rd(CONTROL_OFS, 8'h08, RESP_OKAY);
		// Period codes 0 to 2 through the timed sequence
		for (p = 0; p < 3; p++)
		begin
			wr(CONTROL_OFS, 8'h18, RESP_OKAY);
			wr(CONTROL_OFS, 8'(8'h08 + p), RESP_OKAY);
			rd(CONTROL_OFS, 8'(8'h08 + p), RESP_OKAY);
			kick();
			wp(32 << p);
		end
		wr(STATUS_OFS, 8'h00, RESP_OKAY);
		wp(128);
		repeat (4) @(posedge sys_clk);
		rd(STATUS_OFS, 8'h08, RESP_OKAY);
		// Random kicks keep the timer from expiring
		kick();
		n0 = n_pulse;
		repeat (10)
		begin
			repeat (2 + $urandom % 20) @(posedge sys_clk);
			kick();
		end
		`CHK(n_pulse, n0)
		// Full disable sequence
		wr(CONTROL_OFS, 8'h18, RESP_OKAY);
		wr(CONTROL_OFS, 8'h00, RESP_OKAY);
		rd(CONTROL_OFS, 8'h00, RESP_OKAY);
		n0 = n_pulse;
		repeat (300) @(posedge sys_clk);
		`CHK(n_pulse, n0)
		// Always-on level
		fuse <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rd(CONTROL_OFS, 8'h08, RESP_OKAY);
		kick();
		wp(32);
		wr(CONTROL_OFS, 8'h18, RESP_OKAY);
		wr(CONTROL_OFS, 8'h01, RESP_OKAY);
		rd(CONTROL_OFS, 8'h09, RESP_OKAY);
		kick();
		wp(64);
		test_done();
	end
endmodule
